// *** ssg_pkg.sv ***
package ssg_pkg;
  localparam int unsigned CLK_HZ = 100000000;
  localparam int unsigned FAST_PERIOD_MS = 1000;
  localparam int unsigned FAST_ON_MS = 500;
  localparam int unsigned SLOW_PERIOD_MS = 3000;
  localparam int unsigned SLOW_ON_MS = 300;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned FAST_PERIOD_CYC = FAST_PERIOD_MS * CYC_PER_MS;
  localparam int unsigned FAST_ON_CYC = FAST_ON_MS * CYC_PER_MS;
  localparam int unsigned SLOW_PERIOD_CYC = SLOW_PERIOD_MS * CYC_PER_MS;
  localparam int unsigned SLOW_ON_CYC = SLOW_ON_MS * CYC_PER_MS;
  localparam int unsigned CNT_W = 32;
  localparam int unsigned TONE_W = 16;
  localparam int unsigned GPIO_N = 8;
  localparam logic [1:0] LED_MODE_OFF = 2'h0;
  localparam logic [1:0] LED_MODE_ON = 2'h2;
  localparam logic [3:0] SIM_SEL_OFF = 4'h0;
  localparam logic [3:0] SIM_SEL_MAX = 4'h8;

  typedef enum logic [1:0] {
    NET_OFF,
    NET_SEARCH,
    NET_REGISTERED,
    NET_CALL
  } ssg_net_t;
endpackage

// *** ssg_if.sv ***
`timescale 1ns/10ps
interface ssg_if;
  import ssg_pkg::*;
  logic [CNT_W-1:0] period;
  logic [CNT_W-1:0] on_time;
  logic restart;
  logic run;
  logic wave;
  modport ctrl (output period, output on_time, output restart, output run, input wave);
  modport gen (input period, input on_time, input restart, input run, output wave);
endinterface

// *** ssg_wave_gen.sv ***
`timescale 1ns/10ps
module ssg_wave_gen
  import ssg_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  ssg_if.gen wif
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic wave;
  } ssg_wst_t;

  ssg_wst_t st_q;
  ssg_wst_t st_d;

  always_comb
  begin
    st_d = st_q;
    if (!wif.run || wif.restart)
    begin
      st_d.cnt = '0;
    end
    else if (st_q.cnt + 32'h1 >= wif.period)
    begin
      st_d.cnt = '0;
    end
    else
    begin
      st_d.cnt = st_q.cnt + 32'h1;
    end
    st_d.wave = wif.run && (st_d.cnt < wif.on_time);
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign wif.wave = st_q.wave;
endmodule // ssg_wave_gen

// *** ssg_status_outputs.sv ***
`timescale 1ns/10ps
module ssg_status_outputs
  import ssg_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic alarm_enable_in,
  input wire logic alarm_start_in,
  input wire logic alarm_clear_in,
  input wire logic buzzer_enable_in,
  input wire logic tone_play_in,
  input wire logic [TONE_W-1:0] tone_half_period_in,
  input wire logic [1:0] indicator_mode_command_in,
  input wire logic [1:0] net_status_in,
  input wire logic [3:0] sim_detect_pin_select_command_in,
  input wire logic [GPIO_N-1:0] gpio_pad_in,
  output logic alarm_pad_out,
  output logic buzzer_pad_out,
  output logic network_status_lamp_out,
  output logic indicator_active_out,
  output logic sim_presence_detect_out,
  output logic [3:0] sim_select_readback_out
);
  typedef struct packed {
    logic alarm;
    logic [TONE_W-1:0] tone_cnt;
    logic tone;
    logic led_en;
    ssg_net_t net;
    logic [3:0] sim_sel;
    logic [GPIO_N-1:0] pad_s1;
    logic [GPIO_N-1:0] pad_s2;
    logic sim_det;
    logic led_pin;
  } ssg_st_t;

  ssg_st_t st_q;
  ssg_st_t st_d;
  ssg_if wif ();

  ssg_wave_gen u_wave (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .wif(wif)
  );

  logic lamp;
  logic [3:0] sel_idx;

  always_comb
  begin
    st_d = st_q;
    lamp = 1'b0;
    sel_idx = 4'h0;
    // Alarm: start beats clear in the same cycle
    if (!alarm_enable_in)
    begin
      st_d.alarm = 1'b0;
    end
    else if (alarm_start_in)
    begin
      st_d.alarm = 1'b1;
    end
    else if (alarm_clear_in)
    begin
      st_d.alarm = 1'b0;
    end
    // Buzzer square wave, half period set by tone
    if (!buzzer_enable_in || !tone_play_in)
    begin
      st_d.tone_cnt = '0;
      st_d.tone = 1'b0;
    end
    else if (st_q.tone_cnt + 16'h1 >= tone_half_period_in)
    begin
      st_d.tone_cnt = '0;
      st_d.tone = !st_q.tone;
    end
    else
    begin
      st_d.tone_cnt = st_q.tone_cnt + 16'h1;
    end
    // Indicator mode: only 2 enables, 0 releases
    if (indicator_mode_command_in == LED_MODE_ON)
    begin
      st_d.led_en = 1'b1;
    end
    else if (indicator_mode_command_in == LED_MODE_OFF)
    begin
      st_d.led_en = 1'b0;
    end
    st_d.net = ssg_net_t'(net_status_in);
    unique case (st_q.net)
      NET_OFF: lamp = 1'b0;
      NET_SEARCH: lamp = wif.wave;
      NET_REGISTERED: lamp = wif.wave;
      NET_CALL: lamp = 1'b1;
    endcase
    st_d.led_pin = st_q.led_en ? !lamp : 1'b0;
    // Detect select, out of range values ignored
    if (sim_detect_pin_select_command_in <= SIM_SEL_MAX)
    begin
      st_d.sim_sel = sim_detect_pin_select_command_in;
    end
    st_d.pad_s1 = gpio_pad_in;
    st_d.pad_s2 = st_q.pad_s1;
    sel_idx = st_q.sim_sel - 4'h1;
    if (st_q.sim_sel == SIM_SEL_OFF)
    begin
      st_d.sim_det = 1'b0;
    end
    else
    begin
      st_d.sim_det = st_q.pad_s2[sel_idx[2:0]];
    end
  end

  always_comb
  begin
    wif.run = st_q.led_en && (st_q.net == NET_SEARCH || st_q.net == NET_REGISTERED);
    wif.restart = (st_d.net != st_q.net) || (st_d.led_en != st_q.led_en);
    if (st_q.net == NET_REGISTERED)
    begin
      wif.period = CNT_W'(SLOW_PERIOD_CYC);
      wif.on_time = CNT_W'(SLOW_ON_CYC);
    end
    else
    begin
      wif.period = CNT_W'(FAST_PERIOD_CYC);
      wif.on_time = CNT_W'(FAST_ON_CYC);
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign alarm_pad_out = st_q.alarm;
  assign buzzer_pad_out = st_q.tone;
  assign network_status_lamp_out = st_q.led_pin;
  assign indicator_active_out = st_q.led_en;
  assign sim_presence_detect_out = st_q.sim_det;
  assign sim_select_readback_out = st_q.sim_sel;
endmodule // ssg_status_outputs

// *** ssg_lamp_stage.sv ***
`timescale 1ns/10ps
module ssg_lamp_stage (
  input wire logic pin_in,
  input wire logic en_in,
  output logic lit_out
);
  assign lit_out = en_in & ~pin_in;
endmodule // ssg_lamp_stage

// *** ssg_props.sv ***
`timescale 1ns/10ps
module ssg_props (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic alarm_enable_in,
  input wire logic alarm_start_in,
  input wire logic alarm_clear_in,
  input wire logic [1:0] indicator_mode_command_in,
  input wire logic [1:0] net_status_in,
  input wire logic [3:0] sim_detect_pin_select_command_in,
  input wire logic alarm_pad_out,
  input wire logic network_status_lamp_out,
  input wire logic indicator_active_out,
  input wire logic [3:0] sim_select_readback_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  chk_alarm_set: assert property (alarm_enable_in && alarm_start_in |=> alarm_pad_out)
    else $error("alarm not raised");
  chk_alarm_clear: assert property
    (alarm_enable_in && alarm_clear_in && !alarm_start_in |=> !alarm_pad_out) else $error("clr");
  chk_alarm_hold: assert property
    (alarm_pad_out && alarm_enable_in && !alarm_clear_in |=> alarm_pad_out) else $error("hold");
  chk_lamp_call: assert property
    ((net_status_in == 2'h3 && indicator_active_out) [*3] |-> !network_status_lamp_out)
    else $error("call lamp");
  chk_lamp_dark: assert property
    ((net_status_in == 2'h0 && indicator_active_out) [*3] |-> network_status_lamp_out)
    else $error("off lamp");
  chk_lamp_idle: assert property (!indicator_active_out [*2] |-> !network_status_lamp_out)
    else $error("idle pin");
  chk_mode_on: assert property (indicator_mode_command_in == 2'h2 |=> indicator_active_out)
    else $error("mode on");
  chk_sim_sel: assert property (sim_detect_pin_select_command_in <= 4'h8
    |=> sim_select_readback_out == $past(sim_detect_pin_select_command_in)) else $error("sel");
endmodule // ssg_props
bind ssg_status_outputs ssg_props i_ssg_props (.*);

// *** ssg_status_outputs_tb.sv ***
`timescale 1ns/10ps
module ssg_status_outputs_tb;
  logic clk_sys_in = 0, rst_in = 1, al_en = 0, al_st = 0, al_cl = 0, bz_en = 0, play = 0;
  logic [1:0] mode = 0, net = 0;
  logic [3:0] sel = 0, rb;
  logic [7:0] pad = 0;
  logic [15:0] half = 16'h3;
  logic ap, bp, lp, act, det, lit;
  int errors = 0, checked = 0;
  typedef struct {logic [1:0] m, n; logic p, a;} ssg_row_t;
  ssg_row_t rows [7] = '{'{2'h2, 2'h3, 1'h0, 1'h1}, '{2'h2, 2'h0, 1'h1, 1'h1},
    '{2'h2, 2'h1, 1'h0, 1'h1}, '{2'h2, 2'h2, 1'h0, 1'h1}, '{2'h1, 2'h0, 1'h1, 1'h1},
    '{2'h0, 2'h3, 1'h0, 1'h0}, '{2'h3, 2'h3, 1'h0, 1'h0}};
  always #5 clk_sys_in = ~clk_sys_in;
  ssg_status_outputs i_ssg_status_outputs (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .alarm_enable_in(al_en), .alarm_start_in(al_st), .alarm_clear_in(al_cl),
    .buzzer_enable_in(bz_en), .tone_play_in(play), .tone_half_period_in(half),
    .indicator_mode_command_in(mode), .net_status_in(net),
    .sim_detect_pin_select_command_in(sel), .gpio_pad_in(pad), .alarm_pad_out(ap),
    .buzzer_pad_out(bp), .network_status_lamp_out(lp), .indicator_active_out(act),
    .sim_presence_detect_out(det), .sim_select_readback_out(rb));
  ssg_lamp_stage i_ssg_lamp_stage (.pin_in(lp), .en_in(act), .lit_out(lit));
  task automatic chk(string s, logic [3:0] seen, logic [3:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic step(int k);
    repeat (k) @(posedge clk_sys_in);
    #1;
  endtask
  initial
  begin
    step(16);
    rst_in = 0;
    chk("reset", {ap, bp, lp, act}, 4'h0);
    foreach (rows[i])
    begin
      mode = rows[i].m;
      net = rows[i].n;
      step(4);
      chk("lamp", {1'h0, lp, lit, act},
        {1'h0, rows[i].p, ~rows[i].p & rows[i].a, rows[i].a});
    end
    al_en = 1;
    al_st = 1;
    step(1);
    al_st = 0;
    step(3);
    chk("alarm", {3'h0, ap}, 4'h1);
    al_cl = 1;
    step(1);
    al_cl = 0;
    chk("alarm", {3'h0, ap}, 4'h0);
    bz_en = 1;
    play = 1;
    step(4);
    chk("buzzer", {3'h0, bp}, 4'h1);
    step(1);
    chk("buzzer", {3'h0, bp}, 4'h1);
    step(2);
    chk("buzzer", {3'h0, bp}, 4'h0);
    step(2);
    chk("buzzer", {3'h0, bp}, 4'h1);
    play = 0;
    step(1);
    chk("buzzer", {3'h0, bp}, 4'h0);
    half = 16'h1;
    play = 1;
    step(1);
    chk("buzzer", {3'h0, bp}, 4'h1);
    step(1);
    chk("buzzer", {3'h0, bp}, 4'h0);
    play = 0;
    pad = 8'h10;
    sel = 4'h5;
    step(6);
    chk("sim", {rb[2:0], det}, 4'hb);
    sel = 4'h9;
    step(2);
    chk("sim", rb, 4'h5);
    sel = 4'h0;
    step(2);
    chk("sim", {rb[2:0], det}, 4'h0);
    // Start and clear together, then reset mid-run
    al_st = 1;
    al_cl = 1;
    step(1);
    chk("alarm", {3'h0, ap}, 4'h1);
    al_st = 0;
    al_cl = 0;
    rst_in = 1;
    step(1);
    chk("reset", {ap, bp, lp, act}, 4'h0);
    rst_in = 0;
    step(2);
    chk("alarm", {3'h0, ap}, 4'h0);
    end_of_test;
  end
  initial
  begin
    #20000;
    errors++;
    end_of_test;
  end
endmodule // ssg_status_outputs_tb
